// [src/vdft_frame_timing.sv]
// Display frame timing: control bits, frame size and position counters
//
// Operation
// - Progressive frame shown only while control bit 6 is set.
// - Second field shown only while control bit 5 is set.
// - First field shown only while control bit 4 is set.
// - Control bit 3 always reads zero; writes to it are dropped.
// - Control bits 2..0 pick one of eight output formats.
// - Pixel counter runs from zero to line width minus one, then restarts.
// - Line counter runs from one to frame height inclusive, then restarts.
// - Frame size bits 27..16 hold lines per frame, the line end.
// - Frame size bits 11..0 hold pixels per line, pixel end plus one.
// - Frame size bits 31..28 and 15..12 read zero, writes dropped.
// - Output off while bit 15 is clear; other bits change only then.
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/10ps
module vdft_frame_timing (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [vdft_pkg::ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   output logic displayActive,
   output logic showProgressiveFrame,
   output logic showFirstField,
   output logic showSecondField,
   output logic [2:0] outputFormatSelect,
   output logic [4:0] busWidth,
   output logic [11:0] pixelCount,
   output logic [11:0] lineCount,
   output logic lineStart,
   output logic frameStart
);

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic enable;
      logic frameBit;
      logic field2Bit;
      logic field1Bit;
      vdft_pkg::vdft_format_t format;
      logic [11:0] linesPerFrame;
      logic [11:0] pixelsPerLine;
      vdft_pkg::vdft_state_t state;
      logic [31:0] rdData;
      logic frameOut;
      logic field1Out;
      logic field2Out;
      logic [2:0] formatOut;
      logic [4:0] widthOut;
      logic lineStartOut;
      logic frameStartOut;
   } vdft_state_all_t;

   vdft_state_all_t st_q;
   vdft_state_all_t st_d;

   logic running;
   logic pixWrap;
   logic lineWrap;
   logic [11:0] pixelEnd;
   logic [31:0] controlView;
   logic [31:0] sizeView;

   // ==========================================================
   // Decoding
   // ==========================================================
   function automatic logic [4:0] widthOf(input logic [2:0] fmt);
      logic [4:0] w;
      w = vdft_pkg::WIDTH_8;
      unique case (vdft_pkg::vdft_format_t'(fmt))
         vdft_pkg::FMT_DIGITAL_VIDEO_8BIT: w = vdft_pkg::WIDTH_8;
         vdft_pkg::FMT_DIGITAL_VIDEO_10BIT: w = vdft_pkg::WIDTH_10;
         vdft_pkg::FMT_RAW_8BIT: w = vdft_pkg::WIDTH_8;
         vdft_pkg::FMT_RAW_10BIT: w = vdft_pkg::WIDTH_10;
         vdft_pkg::FMT_LUMA_CHROMA_8BIT: w = vdft_pkg::WIDTH_8;
         vdft_pkg::FMT_LUMA_CHROMA_10BIT: w = vdft_pkg::WIDTH_10;
         vdft_pkg::FMT_RAW_16BIT: w = vdft_pkg::WIDTH_16;
         vdft_pkg::FMT_RAW_20BIT: w = vdft_pkg::WIDTH_20;
      endcase
      return w;
   endfunction

   function automatic logic hits(input logic [3:0] addr,
                                 input logic [3:0] target);
      return addr == target;
   endfunction

   assign running = (st_q.state == vdft_pkg::ST_RUN);

   // A zero width would underflow; treat it as a one-pixel line
   assign pixelEnd = (st_q.pixelsPerLine == 12'h000) ? 12'h000 :
                     12'(st_q.pixelsPerLine - 12'h001);

   // Reserved positions are simply never assigned, so they read zero
   always_comb begin
      controlView = 32'h0000_0000;
      controlView[vdft_pkg::CTL_ENABLE_BIT] = st_q.enable;
      controlView[vdft_pkg::CTL_FRAME_BIT] = st_q.frameBit;
      controlView[vdft_pkg::CTL_FIELD2_BIT] = st_q.field2Bit;
      controlView[vdft_pkg::CTL_FIELD1_BIT] = st_q.field1Bit;
      controlView[vdft_pkg::CTL_FORMAT_LSB +: vdft_pkg::FORMAT_W] =
         st_q.format;
      sizeView = 32'h0000_0000;
      sizeView[vdft_pkg::LINES_LSB +: vdft_pkg::SIZE_W] =
         st_q.linesPerFrame;
      sizeView[vdft_pkg::PIXELS_LSB +: vdft_pkg::SIZE_W] =
         st_q.pixelsPerLine;
   end

   // ==========================================================
   // Position counters
   // ==========================================================
   vdft_wrap_counter #(
      .W(vdft_pkg::SIZE_W),
      .START(vdft_pkg::PIXEL_START)
   ) u_pixel_counter (
      .mclk(mclk),
      .reset_n(reset_n),
      .clear(!running),
      .advance(running),
      .endValue(pixelEnd),
      .count(pixelCount),
      .wrap(pixWrap)
   );

   vdft_wrap_counter #(
      .W(vdft_pkg::SIZE_W),
      .START(vdft_pkg::LINE_START)
   ) u_line_counter (
      .mclk(mclk),
      .reset_n(reset_n),
      .clear(!running),
      .advance(pixWrap),
      .endValue(st_q.linesPerFrame),
      .count(lineCount),
      .wrap(lineWrap)
   );

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      st_d = st_q;
      st_d.rdData = 32'h0000_0000;

      if (regWrite && hits(regAddr, vdft_pkg::ADDR_CONTROL)) begin
         st_d.enable = regWrData[vdft_pkg::CTL_ENABLE_BIT];
         // Mode bits are locked while enabled, so a live frame never
         // sees its format or field choice flip mid-line
         if (!st_q.enable) begin
            st_d.frameBit = regWrData[vdft_pkg::CTL_FRAME_BIT];
            st_d.field2Bit = regWrData[vdft_pkg::CTL_FIELD2_BIT];
            st_d.field1Bit = regWrData[vdft_pkg::CTL_FIELD1_BIT];
            st_d.format = vdft_pkg::vdft_format_t'(
               regWrData[vdft_pkg::CTL_FORMAT_LSB +: vdft_pkg::FORMAT_W]);
         end
      end
      if (regWrite && hits(regAddr, vdft_pkg::ADDR_FRAME_SIZE) &&
          !st_q.enable) begin
         st_d.linesPerFrame =
            regWrData[vdft_pkg::LINES_LSB +: vdft_pkg::SIZE_W];
         st_d.pixelsPerLine =
            regWrData[vdft_pkg::PIXELS_LSB +: vdft_pkg::SIZE_W];
      end

      if (regRead) begin
         if (hits(regAddr, vdft_pkg::ADDR_CONTROL)) begin
            st_d.rdData = controlView;
         end else if (hits(regAddr, vdft_pkg::ADDR_FRAME_SIZE)) begin
            st_d.rdData = sizeView;
         end
      end

      unique case (st_q.state)
         vdft_pkg::ST_IDLE: begin
            if (st_q.enable) begin
               st_d.state = vdft_pkg::ST_RUN;
            end
         end
         vdft_pkg::ST_RUN: begin
            if (!st_q.enable) begin
               st_d.state = vdft_pkg::ST_IDLE;
            end
         end
         default: st_d.state = vdft_pkg::ST_IDLE;
      endcase

      st_d.frameOut = running && st_q.frameBit;
      st_d.field2Out = running && st_q.field2Bit;
      st_d.field1Out = running && st_q.field1Bit;
      st_d.formatOut = st_q.format;
      st_d.widthOut = widthOf(st_q.format);
      st_d.lineStartOut = pixWrap;
      st_d.frameStartOut = lineWrap;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '{
            enable: vdft_pkg::CTL_ENABLE_RESET,
            frameBit: vdft_pkg::CTL_FLAG_RESET,
            field2Bit: vdft_pkg::CTL_FLAG_RESET,
            field1Bit: vdft_pkg::CTL_FLAG_RESET,
            format: vdft_pkg::vdft_format_t'(vdft_pkg::CTL_FORMAT_RESET),
            linesPerFrame: vdft_pkg::LINES_RESET,
            pixelsPerLine: vdft_pkg::PIXELS_RESET,
            state: vdft_pkg::ST_IDLE,
            rdData: 32'h0000_0000,
            frameOut: 1'b0,
            field1Out: 1'b0,
            field2Out: 1'b0,
            formatOut: vdft_pkg::CTL_FORMAT_RESET,
            widthOut: vdft_pkg::WIDTH_8,
            lineStartOut: 1'b0,
            frameStartOut: 1'b0
         };
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign regRdData = st_q.rdData;
   assign displayActive = running;
   assign showProgressiveFrame = st_q.frameOut;
   assign showFirstField = st_q.field1Out;
   assign showSecondField = st_q.field2Out;
   assign outputFormatSelect = st_q.formatOut;
   assign busWidth = st_q.widthOut;
   assign lineStart = st_q.lineStartOut;
   assign frameStart = st_q.frameStartOut;

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   property p_frame_shown;
      (running && st_q.frameBit) ##1 running |-> showProgressiveFrame;
   endproperty
   a_frame_shown: assert property (p_frame_shown)
      else $error("frame not shown with frame bit set");

   property p_frame_hidden;
      !st_q.frameBit |=> !showProgressiveFrame;
   endproperty
   a_frame_hidden: assert property (p_frame_hidden)
      else $error("frame shown with frame bit clear");

   property p_field2;
      showSecondField |-> $past(st_q.field2Bit) && $past(running);
   endproperty
   a_field2: assert property (p_field2)
      else $error("second field shown without its bit");

   property p_field1;
      showFirstField |-> $past(st_q.field1Bit) && $past(running);
   endproperty
   a_field1: assert property (p_field1)
      else $error("first field shown without its bit");

   property p_ctl_reserved;
      regRead && regAddr == vdft_pkg::ADDR_CONTROL
         |=> regRdData[vdft_pkg::CTL_RESERVED_BIT] == 1'b0;
   endproperty
   a_ctl_reserved: assert property (p_ctl_reserved)
      else $error("control reserved bit read nonzero");

   // Checked against the code table directly, not through the decoder
   property p_width_match;
      busWidth == (outputFormatSelect == 3'h7 ? vdft_pkg::WIDTH_20 :
                   outputFormatSelect == 3'h6 ? vdft_pkg::WIDTH_16 :
                   outputFormatSelect[0] ? vdft_pkg::WIDTH_10 :
                   vdft_pkg::WIDTH_8);
   endproperty
   a_width_match: assert property (p_width_match)
      else $error("bus width does not match format");

   property p_pixel_step;
      running && pixelCount < pixelEnd
         |=> pixelCount == 12'($past(pixelCount) + 12'h001);
   endproperty
   a_pixel_step: assert property (p_pixel_step)
      else $error("pixel counter failed to step");

   property p_pixel_wrap;
      running && pixelCount >= pixelEnd |=> pixelCount == 12'h000;
   endproperty
   a_pixel_wrap: assert property (p_pixel_wrap)
      else $error("pixel counter failed to restart");

   property p_line_wrap;
      pixWrap && lineCount >= st_q.linesPerFrame
         |=> lineCount == 12'h001 && frameStart;
   endproperty
   a_line_wrap: assert property (p_line_wrap)
      else $error("line counter failed to restart at one");

   property p_size_read;
      regRead && regAddr == vdft_pkg::ADDR_FRAME_SIZE
         |=> regRdData[27:16] == $past(st_q.linesPerFrame) &&
             regRdData[11:0] == $past(st_q.pixelsPerLine) &&
             regRdData[31:28] == 4'h0 && regRdData[15:12] == 4'h0;
   endproperty
   a_size_read: assert property (p_size_read)
      else $error("frame size readback wrong");

   property p_locked;
      st_q.enable && regWrite |=> $stable(st_q.format) &&
         $stable(st_q.pixelsPerLine) && $stable(st_q.linesPerFrame) &&
         $stable(st_q.frameBit) && $stable(st_q.field1Bit) &&
         $stable(st_q.field2Bit);
   endproperty
   a_locked: assert property (p_locked)
      else $error("settings changed while enabled");

   property p_line_hold;
      running && !pixWrap |=> $stable(lineCount);
   endproperty
   a_line_hold: assert property (p_line_hold)
      else $error("line counter moved without pixel wrap");

   property p_idle_hold;
      !running [*2] |-> pixelCount == 12'h000 && lineCount == 12'h001;
   endproperty
   a_idle_hold: assert property (p_idle_hold)
      else $error("counters moved while disabled");

   cp_enable: cover property (!running ##1 running);
   cp_line: cover property (pixWrap && !lineWrap);
   cp_frame: cover property (lineWrap ##1 frameStart);
   cp_lock: cover property (st_q.enable && regWrite &&
                            regAddr == vdft_pkg::ADDR_CONTROL);

endmodule // vdft_frame_timing

// [src/vdft_pkg.sv]
// Constants and types shared by the display frame timing block
package vdft_pkg;

   // ==========================================================
   // Register map (byte addresses on the plain register port)
   // ==========================================================
   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_FRAME_SIZE = 4'h4;

   // ==========================================================
   // Control register fields
   // ==========================================================
   localparam int CTL_ENABLE_BIT = 15;
   localparam int CTL_FRAME_BIT = 6;
   localparam int CTL_FIELD2_BIT = 5;
   localparam int CTL_FIELD1_BIT = 4;
   localparam int CTL_RESERVED_BIT = 3;
   localparam int CTL_FORMAT_LSB = 0;
   localparam int FORMAT_W = 3;
   localparam logic CTL_ENABLE_RESET = 1'h0;
   localparam logic CTL_FLAG_RESET = 1'h0;
   localparam logic [2:0] CTL_FORMAT_RESET = 3'h0;

   // ==========================================================
   // Frame size register fields
   // ==========================================================
   localparam int SIZE_W = 12;
   localparam int LINES_LSB = 16;
   localparam int PIXELS_LSB = 0;
   localparam logic [11:0] LINES_RESET = 12'h000;
   localparam logic [11:0] PIXELS_RESET = 12'h000;

   // ==========================================================
   // Counter start values
   // ==========================================================
   localparam logic [11:0] PIXEL_START = 12'h000;
   localparam logic [11:0] LINE_START = 12'h001;

   // ==========================================================
   // Output format codes and bus widths
   // ==========================================================
   typedef enum logic [2:0] {
      FMT_DIGITAL_VIDEO_8BIT = 3'h0,
      FMT_DIGITAL_VIDEO_10BIT = 3'h1,
      FMT_RAW_8BIT = 3'h2,
      FMT_RAW_10BIT = 3'h3,
      FMT_LUMA_CHROMA_8BIT = 3'h4,
      FMT_LUMA_CHROMA_10BIT = 3'h5,
      FMT_RAW_16BIT = 3'h6,
      FMT_RAW_20BIT = 3'h7
   } vdft_format_t;

   localparam logic [4:0] WIDTH_8 = 5'h08;
   localparam logic [4:0] WIDTH_10 = 5'h0A;
   localparam logic [4:0] WIDTH_16 = 5'h10;
   localparam logic [4:0] WIDTH_20 = 5'h14;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } vdft_state_t;

endpackage

// [src/vdft_wrap_counter.sv]
// Up counter that restarts at a fixed value after a programmed end
`timescale 1ns/10ps
module vdft_wrap_counter #(
   parameter int W = 12,
   parameter logic [W-1:0] START = '0
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clear,
   input wire logic advance,
   input wire logic [W-1:0] endValue,
   output logic [W-1:0] count,
   output logic wrap
);

   typedef struct packed {
      logic [W-1:0] count;
   } vdft_cnt_state_t;

   vdft_cnt_state_t st_q;
   vdft_cnt_state_t st_d;

   // A count at or past the end restarts, so a lowered end never runs away
   assign wrap = advance && (st_q.count >= endValue);
   assign count = st_q.count;

   always_comb begin
      st_d = st_q;
      if (clear || wrap) begin
         st_d.count = START;
      end else if (advance) begin
         st_d.count = W'(st_q.count + 1'b1);
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '{count: START};
      end else begin
         st_q <= st_d;
      end
   end

endmodule // vdft_wrap_counter

// [tb/tb_top.sv]
// Self-checking bench for the display frame timing block
`timescale 1ns/10ps
module tb_top;
   logic mclk, reset_n, regWrite, regRead, displayActive, lineStart;
   logic showProgressiveFrame, showFirstField, showSecondField, frameStart;
   logic [3:0] regAddr;
   logic [31:0] regWrData, regRdData, rnd, ctl, expQ[$];
   logic [2:0] outputFormatSelect;
   logic [4:0] busWidth;
   logic [11:0] pixelCount, lineCount, lineLen;
   logic rdLate = 1'b0;
   int fails, tests_run, w, h;
   logic [4:0] widths[8] = '{5'h08, 5'h0A, 5'h08, 5'h0A, 5'h08, 5'h0A,
                            5'h10, 5'h14};

   vdft_frame_timing uut (.mclk(mclk), .reset_n(reset_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
      .regRead(regRead), .regRdData(regRdData),
      .displayActive(displayActive),
      .showProgressiveFrame(showProgressiveFrame),
      .showFirstField(showFirstField), .showSecondField(showSecondField),
      .outputFormatSelect(outputFormatSelect), .busWidth(busWidth),
      .pixelCount(pixelCount), .lineCount(lineCount),
      .lineStart(lineStart), .frameStart(frameStart));
   vdft_sink_model sink (.mclk(mclk), .reset_n(reset_n),
      .displayActive(displayActive), .lineStart(lineStart),
      .lineLen(lineLen));

   always #25 mclk = ~mclk;

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      expQ.push_back(exp);
      @(posedge mclk);
      regRead <= 1'b0;
   endtask

   // ==========================================================
   // Read data watcher
   // ==========================================================
   // Sampled mid-cycle so the registered answer has settled
   always @(negedge mclk) begin
      if (rdLate && expQ.size() > 0)
         chk(regRdData, expQ.pop_front());
      rdLate = regRead;
   end

   // Enable was taken at the last edge; the first checked cycle is c2
   task automatic runChk(input int cw, input int ch, input logic [31:0] c,
                         input int n);
      int k, p;
      for (k = -1; k < n; k++) begin
         @(negedge mclk);
         if (k >= 0) begin
            p = k % cw;
            chk(pixelCount, 32'(p));
            chk(lineCount, 32'(1 + (k / cw) % ch));
            chk(lineStart, 32'(k > 0 && p == 0));
            chk(frameStart, 32'(k > 0 && k % (cw * ch) == 0));
            chk(displayActive, 32'h1);
         end
         if (k >= 1) begin
            chk(showProgressiveFrame, 32'(c[6]));
            chk(showSecondField, 32'(c[5]));
            chk(showFirstField, 32'(c[4]));
            chk(outputFormatSelect, 32'(c[2:0]));
            chk(busWidth, 32'(widths[c[2:0]]));
         end
      end
   endtask

   task automatic stopChk();
      wr(4'h0, 32'h0000_0000);
      // Enable drops at once, run state one edge later, counters one more
      repeat (3) @(negedge mclk);
      chk(pixelCount, 32'h0);
      chk(lineCount, 32'h1);
      chk(displayActive, 32'h0);
      chk(showProgressiveFrame | showFirstField | showSecondField,
          32'h0);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #(50 * 60000);
      fails++;
      results();
   end

   initial begin
      mclk = 1'b0;
      reset_n = 1'b0;
      regAddr = 4'h0;
      regWrData = 32'h0;
      regWrite = 1'b0;
      regRead = 1'b0;
      rnd = 32'd21979;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      // ========================================================
      // Reset state and unmapped place
      // ========================================================
      rd(4'h0, 32'h0);
      rd(4'h4, 32'h0);
      rd(4'h8, 32'h0);
      @(negedge mclk);
      chk(pixelCount, 32'h0);
      chk(lineCount, 32'h1);
      chk(busWidth, 32'h08);
      $display("test reset done");
      // ========================================================
      // Every format with random flags and a small frame
      // ========================================================
      for (int f = 0; f < 8; f++) begin
         rnd = xs(rnd);
         w = 2 + rnd[1:0];
         h = 1 + rnd[3:2] % 3;
         ctl = {rnd[31:16], 1'b0, rnd[14:3], 3'(f)};
         wr(4'h0, ctl);
         wr(4'h4, {rnd[31:28], 12'(h), rnd[15:12], 12'(w)});
         rd(4'h0, ctl & 32'h0000_0077);
         rd(4'h4, {4'h0, 12'(h), 4'h0, 12'(w)});
         wr(4'h0, ctl | 32'h0000_8000);
         runChk(w, h, ctl, 2 * w * h + 2);
         chk(lineLen, 32'(w));
         wr(4'h4, 32'h0001_0001);
         wr(4'h0, ~ctl | 32'h0000_8000);
         rd(4'h4, {4'h0, 12'(h), 4'h0, 12'(w)});
         rd(4'h0, (ctl & 32'h0000_0077) | 32'h0000_8000);
         stopChk();
         $display("test format %0d done", f);
      end
      // ========================================================
      // Standard sizes, reserved bits written as ones
      // ========================================================
      wr(4'h4, 32'hF271_F360);
      rd(4'h4, 32'h0271_0360);
      wr(4'h4, 32'hF20D_F35A);
      rd(4'h4, 32'h020D_035A);
      wr(4'h0, 32'h0000_8000);
      runChk(858, 525, 32'h0, 900);
      stopChk();
      $display("test standard done");
      results();
   end
endmodule // tb_top

// [tb/vdft_sink_model.sv]
// Display sink model: measures the line length seen on the timing outputs
`timescale 1ns/10ps
module vdft_sink_model (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic displayActive,
   input wire logic lineStart,
   output logic [11:0] lineLen
);
   logic [11:0] cnt;
   // ==========================================================
   // Line length
   // ==========================================================
   // One pixel is taken on every clock while displayActive is high; a line ends at each pulse
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 12'h000;
         lineLen <= 12'h000;
      end else if (lineStart) begin
         lineLen <= cnt;
         cnt <= 12'h001;
      end else if (displayActive) begin
         cnt <= cnt + 12'h001;
      end
   end
endmodule // vdft_sink_model
